//--- rtl/tx_port_mux.sv
// How it works
// R1: Low level on a low-active float port floats the line, ORed with bit.
// R2: Each transmit pin carries the signal its four-bit function code selects.
// R3: After reset every transmit multifunction pin is an input.
// R4: Pin direction follows the selected function automatically.
// R5: Edge-select bit picks rising or falling system clock edge for port data.
// R6: An undriven input pin reads high through its pull-up.
// R7: Software selects each input function on at most one port per channel.
// R8: Software never enables sync pulse and multiframe sync together.
// R9: Four channels, each with four transmit multifunction ports.
// R10: Interface strap always selects host interface; upper bit means serial.
// R11: Message serial mode only: address straps give six slave address bits.
// R12: Serial modes: data straps set PLL dividers M and N.
// R13: Strapped dividers behave like register fields used in parallel modes.
// R14: Host register address space is 10 bits wide.
// R15: Handshake output driven only when ready-enable pin is high.
// R16: High level on a high-active float port floats the line, ORed with bit.
// R17: Strap codes 00 and 01 select the parallel Intel or Motorola bus.
// R18: Straps captured at reset release and held until next reset.
//
// Strobed register access and the register offsets were decided locally.
module tx_port_mux
(
  input wire logic ref_clk,                                   // Core clock, 125 MHz
  input wire logic rst_n,                                     // Async reset, active low
  input wire logic [txmux_pkg::ADDR_W-1:0] addr,              // Register address
  input wire logic [txmux_pkg::DATA_W-1:0] wdata,             // Write data
  input wire logic wr_stb,                                    // Write strobe
  input wire logic rd_stb,                                    // Read strobe
  output logic [txmux_pkg::DATA_W-1:0] rdata,                 // Read data, cycle after strobe
  input wire logic [txmux_pkg::NUM_PIN-1:0] tx_port_i,        // Pin levels, ch*4+port
  output logic [txmux_pkg::NUM_PIN-1:0] tx_port_o,            // Pin drive values
  output logic [txmux_pkg::NUM_PIN-1:0] tx_port_oe_n,         // Low while driving
  input wire logic [txmux_pkg::NUM_CH-1:0] tx_system_clock,   // System clock pins
  input wire logic [txmux_pkg::NUM_CH-1:0] tx_mfb_src,        // Multiframe begin from core
  input wire logic [txmux_pkg::NUM_CH-1:0] tx_sigm_src,       // Signaling marker from core
  input wire logic [txmux_pkg::NUM_CH-1:0] tx_dlx_src,        // Data link marker from core
  input wire logic [txmux_pkg::NUM_CH-1:0] tx_xclk_src,       // Line clock from core
  output logic [txmux_pkg::NUM_CH-1:0] tx_sync_pulse_in,      // To core
  output logic [txmux_pkg::NUM_CH-1:0] tx_multiframe_sync_in, // To core
  output logic [txmux_pkg::NUM_CH-1:0] tx_signaling_in,       // To core
  output logic [txmux_pkg::NUM_CH-1:0] tx_clock_in,           // To core
  output logic [txmux_pkg::NUM_CH-1:0] tx_line_float_ctl,     // Line float per channel
  input wire logic [1:0] host_if_strap,                       // Interface strap pins
  input wire logic [5:0] addr_strap,                          // Address strap pins
  input wire logic [15:5] data_strap,                         // Data strap pins
  output logic [1:0] host_if_sel,                             // Captured interface
  output logic [5:0] slave_addr,                              // Strapped slave address bits
  output logic [txmux_pkg::PLL_M_W-1:0] pll_m_divider,        // Effective divider M
  output logic [txmux_pkg::PLL_N_W-1:0] pll_n_divider,        // Effective divider N
  output logic strap_valid,                                   // Straps captured
  input wire logic ready_en,                                  // Ready-enable pin
  input wire logic hs_drive_req,                              // Bus logic wants handshake low
  output logic host_handshake_out,                            // Open-drain value
  output logic host_handshake_oe_n                            // Low while pulling low
);
  port_cfg_if cfg_bus ();

  logic [txmux_pkg::DATA_W-1:0] tx_ctl_r;
  logic [txmux_pkg::PLL_M_W-1:0] pll_m_reg_r;
  logic [txmux_pkg::PLL_N_W-1:0] pll_n_reg_r;
  logic [txmux_pkg::NUM_PIN-1:0] pin_s1_r, pin_s2_r;
  logic [txmux_pkg::NUM_PIN-1:0] cap_q, port_q, oe_n_q, out_fn;
  logic [txmux_pkg::NUM_CH-1:0] edge_ev;
  logic [18:0] strap_s1_r, strap_s2_r;
  logic [1:0] strap_cnt_r;
  logic strap_done_r;
  logic [1:0] host_sel_r;
  logic [5:0] saddr_r;
  logic [txmux_pkg::PLL_M_W-1:0] strap_m_r, pll_m_r;
  logic [txmux_pkg::PLL_N_W-1:0] strap_n_r, pll_n_r;
  logic [1:0] ready_s_r;
  logic hs_oe_n_r;
  logic [txmux_pkg::NUM_CH-1:0] sync_r, mfs_r, sig_r, tx_clock_in_r, float_r;
  logic [txmux_pkg::DATA_W-1:0] aux_nxt;

  ////////////////////////////////////////////////////////////////
  // R14: ten-bit address
  // Bank holds the per-channel port config words and the read register
  port_cfg_bank u_bank (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bus     (cfg_bus.bank)
  );

  assign cfg_bus.addr = addr;
  assign cfg_bus.wdata = wdata;
  assign cfg_bus.we = wr_stb;
  assign cfg_bus.re = rd_stb;
  assign cfg_bus.aux_rdata = aux_nxt;
  assign rdata = cfg_bus.rdata;

  ////////////////////////////////////////////////////////////////
  // Control registers written by software
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_ctl_r <= txmux_pkg::TX_CTL_RST;
      pll_m_reg_r <= txmux_pkg::PLL_M_RST;
      pll_n_reg_r <= txmux_pkg::PLL_N_RST;
    end
    else if (wr_stb && addr == txmux_pkg::OFS_TX_CTL)
      tx_ctl_r <= wdata;
    else if (wr_stb && addr == txmux_pkg::OFS_PLL_CFG)
    begin
      pll_m_reg_r <= wdata[txmux_pkg::PLL_M_LSB +: txmux_pkg::PLL_M_W];
      pll_n_reg_r <= wdata[txmux_pkg::PLL_N_LSB +: txmux_pkg::PLL_N_W];
    end
  end

  // Read mux for everything outside the bank; unmapped reads zero
  always_comb
  begin
    aux_nxt = '0;
    case (addr)
      txmux_pkg::OFS_TX_CTL: aux_nxt = tx_ctl_r;
      txmux_pkg::OFS_PLL_CFG:
      begin
        aux_nxt[txmux_pkg::PLL_M_LSB +: txmux_pkg::PLL_M_W] = pll_m_reg_r;
        aux_nxt[txmux_pkg::PLL_N_LSB +: txmux_pkg::PLL_N_W] = pll_n_reg_r;
      end
      txmux_pkg::OFS_STRAP_STAT:
      begin
        aux_nxt[txmux_pkg::STS_HOST_LSB +: 2] = host_sel_r;
        aux_nxt[txmux_pkg::STS_SADDR_LSB +: 6] = saddr_r;
        aux_nxt[txmux_pkg::STS_DONE_BIT] = strap_done_r;
      end
      txmux_pkg::OFS_PLL_EFF:
      begin
        aux_nxt[txmux_pkg::PLL_M_LSB +: txmux_pkg::PLL_M_W] = pll_m_r;
        aux_nxt[txmux_pkg::PLL_N_LSB +: txmux_pkg::PLL_N_W] = pll_n_r;
      end
      // R6: pull-up level
      // An open input pin shows up here as one
      txmux_pkg::OFS_PIN_LEVEL: aux_nxt = pin_s2_r;
      txmux_pkg::OFS_FLOAT_STAT: aux_nxt[txmux_pkg::NUM_CH-1:0] = float_r;
      default: aux_nxt = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers; pins are asynchronous to the core clock
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
      ready_s_r <= '0;
    end
    else
    begin
      pin_s1_r <= tx_port_i;
      pin_s2_r <= pin_s1_r;
      ready_s_r <= {ready_s_r[0], ready_en};
    end
  end

  ////////////////////////////////////////////////////////////////
  // R9: four by four ports
  for (genvar ch = 0; ch < txmux_pkg::NUM_CH; ch++)
  begin : g_ch
    logic [2:0] sclk_r;
    logic rise, fall;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        sclk_r <= '0;
      else
        sclk_r <= {sclk_r[1:0], tx_system_clock[ch]};
    end

    assign rise = sclk_r[1] && !sclk_r[2];
    assign fall = !sclk_r[1] && sclk_r[2];
    // R5: edge select
    // Falling edge when the bit is set, rising otherwise
    assign edge_ev[ch] = tx_ctl_r[txmux_pkg::TXC_EDGE_LSB + ch] ? fall : rise;

    for (genvar p = 0; p < txmux_pkg::NUM_PORT; p++)
    begin : g_port
      localparam int K = ch * txmux_pkg::NUM_PORT + p;
      logic [txmux_pkg::CODE_W-1:0] code;
      logic cap_r, port_r, oe_n_r, port_nxt;

      assign code = cfg_bus.cfg[K*txmux_pkg::CODE_W +: txmux_pkg::CODE_W];
      assign out_fn[K] = txmux_pkg::is_output(code);

      // Frame-timed inputs are sampled only on the chosen edge
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          cap_r <= 1'b1;
        else if (edge_ev[ch])
          cap_r <= pin_s2_r[K];
      end

      // R2: function select
      // Markers launch on the chosen edge; clock and fixed levels follow directly
      always_comb
      begin
        port_nxt = 1'b1;
        case (code)
          txmux_pkg::FN_MFB: port_nxt = edge_ev[ch] ? tx_mfb_src[ch] : port_r;
          txmux_pkg::FN_SIGM: port_nxt = edge_ev[ch] ? tx_sigm_src[ch] : port_r;
          txmux_pkg::FN_DLX: port_nxt = edge_ev[ch] ? tx_dlx_src[ch] : port_r;
          txmux_pkg::FN_XCLK: port_nxt = tx_xclk_src[ch];
          txmux_pkg::FN_GPOH: port_nxt = 1'b1;
          txmux_pkg::FN_GPOL: port_nxt = 1'b0;
          default: port_nxt = 1'b1;
        endcase
      end

      // R4: automatic direction
      // No separate direction control; the code alone decides
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          port_r <= 1'b1;
          oe_n_r <= 1'b1;
        end
        else
        begin
          port_r <= port_nxt;
          oe_n_r <= !out_fn[K];
        end
      end

      assign cap_q[K] = cap_r;
      assign port_q[K] = port_r;
      assign oe_n_q[K] = oe_n_r;

      // R4: direction follows code
      dir_auto_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        ##1 oe_n_r == !$past(out_fn[K]))
        else $error("port direction does not follow function code");
      // R5: launch only on edge
      edge_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        (code == txmux_pkg::FN_MFB && $past(code) == txmux_pkg::FN_MFB && !edge_ev[ch]) |=> $stable(port_r))
        else $error("marker output changed without selected edge");
      // R2: fixed low output level
      gpo_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
        (code == txmux_pkg::FN_GPOL) |=> !port_r && !oe_n_r)
        else $error("fixed low output not driven low");
    end

    // R7: one port per input
    // Ports are ORed, so a duplicated input function merges rather than fails
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        sync_r[ch] <= 1'b0;
        mfs_r[ch] <= 1'b0;
        sig_r[ch] <= 1'b0;
        tx_clock_in_r[ch] <= 1'b0;
        float_r[ch] <= 1'b0;
      end
      else
      begin
        logic s, m, g, t, fh, fl;
        logic [txmux_pkg::CODE_W-1:0] c;
        s = 1'b0;
        m = 1'b0;
        g = 1'b0;
        t = 1'b0;
        fh = 1'b0;
        fl = 1'b0;
        for (int p = 0; p < txmux_pkg::NUM_PORT; p++)
        begin
          c = cfg_bus.cfg[(ch*txmux_pkg::NUM_PORT+p)*txmux_pkg::CODE_W +: txmux_pkg::CODE_W];
          if (c == txmux_pkg::FN_SYNC) s = s | cap_q[ch*txmux_pkg::NUM_PORT+p];
          if (c == txmux_pkg::FN_MFS) m = m | cap_q[ch*txmux_pkg::NUM_PORT+p];
          if (c == txmux_pkg::FN_SIG) g = g | cap_q[ch*txmux_pkg::NUM_PORT+p];
          if (c == txmux_pkg::FN_TX_CLOCK_IN) t = t | pin_s2_r[ch*txmux_pkg::NUM_PORT+p];
          // R16: high-active float
          if (c == txmux_pkg::FN_FLOAT_HI) fh = fh | pin_s2_r[ch*txmux_pkg::NUM_PORT+p];
          // R1: low-active float
          if (c == txmux_pkg::FN_FLOAT_LO) fl = fl | !pin_s2_r[ch*txmux_pkg::NUM_PORT+p];
        end
        sync_r[ch] <= s;
        mfs_r[ch] <= m;
        sig_r[ch] <= g;
        tx_clock_in_r[ch] <= t;
        // R1: ORed with float bit
        float_r[ch] <= fh | fl | tx_ctl_r[txmux_pkg::TXC_FLOAT_LSB + ch];
      end
    end

    // R1: low level floats line
    float_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
      (cfg_bus.cfg[ch*txmux_pkg::DATA_W +: txmux_pkg::CODE_W] == txmux_pkg::FN_FLOAT_LO && !pin_s2_r[ch*4])
      |=> float_r[ch])
      else $error("low-active float pin did not float the line");
    // R16: high level floats line
    float_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
      (cfg_bus.cfg[ch*txmux_pkg::DATA_W +: txmux_pkg::CODE_W] == txmux_pkg::FN_FLOAT_HI && pin_s2_r[ch*4])
      |=> float_r[ch])
      else $error("high-active float pin did not float the line");
  end

  assign tx_port_o = port_q;
  assign tx_port_oe_n = oe_n_q;
  assign tx_sync_pulse_in = sync_r;
  // R8: sync versus multiframe
  // Both are passed on as they are; the core is not protected against both
  assign tx_multiframe_sync_in = mfs_r;
  assign tx_signaling_in = sig_r;
  assign tx_clock_in = tx_clock_in_r;
  assign tx_line_float_ctl = float_r;

  // R3: all inputs at release
  reset_input_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    $rose(rst_n) |-> (&tx_port_oe_n))
    else $error("port driving right after reset");

  ////////////////////////////////////////////////////////////////
  // R18: capture at release
  // Counter lets the synchronisers fill before the levels are taken once
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_s1_r <= '0;
      strap_s2_r <= '0;
      strap_cnt_r <= '0;
      strap_done_r <= 1'b0;
      host_sel_r <= txmux_pkg::HOST_INTEL;
      saddr_r <= '0;
      strap_m_r <= '0;
      strap_n_r <= '0;
    end
    else
    begin
      strap_s1_r <= {host_if_strap, addr_strap, data_strap};
      strap_s2_r <= strap_s1_r;
      if (!strap_done_r)
      begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
        if (strap_cnt_r == txmux_pkg::STRAP_DLY)
        begin
          strap_done_r <= 1'b1;
          // R10: interface strap
          host_sel_r <= strap_s2_r[18:17];
          // R11: slave address only in message mode
          saddr_r <= (strap_s2_r[18:17] == txmux_pkg::HOST_MSG_SERIAL) ? strap_s2_r[16:11] : 6'h00;
          // R12: divider straps
          strap_m_r <= strap_s2_r[txmux_pkg::STRAP_M_LSB-5 +: txmux_pkg::PLL_M_W];
          strap_n_r <= strap_s2_r[txmux_pkg::STRAP_N_LSB-5 +: txmux_pkg::PLL_N_W];
        end
      end
    end
  end

  // R13: same path as register
  // One divider register feeds the PLL whichever source wins
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_m_r <= txmux_pkg::PLL_M_RST;
      pll_n_r <= txmux_pkg::PLL_N_RST;
    end
    else if (strap_done_r && host_sel_r[txmux_pkg::HOST_SERIAL_BIT])
    begin
      pll_m_r <= strap_m_r;
      pll_n_r <= strap_n_r;
    end
    else
    begin
      pll_m_r <= pll_m_reg_r;
      pll_n_r <= pll_n_reg_r;
    end
  end

  // R15: handshake enable
  // R17: parallel modes only
  // Open drain: never driven high, only pulled low on request
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hs_oe_n_r <= 1'b1;
    else
      hs_oe_n_r <= !(ready_s_r[1] && hs_drive_req && strap_done_r &&
                     (host_sel_r == txmux_pkg::HOST_INTEL || host_sel_r == txmux_pkg::HOST_MOTOROLA));
  end

  assign host_if_sel = host_sel_r;
  assign slave_addr = saddr_r;
  assign pll_m_divider = pll_m_r;
  assign pll_n_divider = pll_n_r;
  assign strap_valid = strap_done_r;
  assign host_handshake_out = 1'b0;
  assign host_handshake_oe_n = hs_oe_n_r;

  // R18: straps held
  strap_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R18
    strap_done_r |=> strap_done_r && $stable(host_sel_r) && $stable(saddr_r))
    else $error("strapped values changed after capture");
  // R12: serial uses straps
  pll_strap_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
    (strap_done_r && host_sel_r[txmux_pkg::HOST_SERIAL_BIT]) |=> pll_m_r == $past(strap_m_r) && pll_n_r == $past(strap_n_r))
    else $error("serial mode divider not from straps");
  // R13: parallel uses register
  pll_reg_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
    !host_sel_r[txmux_pkg::HOST_SERIAL_BIT] |=> pll_m_r == $past(pll_m_reg_r) && pll_n_r == $past(pll_n_reg_r))
    else $error("parallel mode divider not from register");
  // R11: address only in message mode
  slave_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
    (host_sel_r != txmux_pkg::HOST_MSG_SERIAL) |-> saddr_r == 6'h00)
    else $error("slave address set outside message serial mode");
  // R15: tied-low enable floats
  handshake_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
    !ready_s_r[1] |=> hs_oe_n_r)
    else $error("handshake driven while enable pin low");
endmodule : tx_port_mux

//--- rtl/txmux_pkg.sv
package txmux_pkg;
  // Bus and array geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 4;
  localparam int NUM_PORT = 4;
  localparam int CODE_W = 4;
  localparam int NUM_PIN = NUM_CH * NUM_PORT;
  localparam int CFG_W = NUM_PIN * CODE_W;

  // Register offsets (word addresses on the plain port)
  localparam logic [ADDR_W-1:0] OFS_PORT_CFG0 = 10'h000;
  localparam logic [ADDR_W-1:0] OFS_TX_CTL = 10'h004;
  localparam logic [ADDR_W-1:0] OFS_PLL_CFG = 10'h005;
  localparam logic [ADDR_W-1:0] OFS_STRAP_STAT = 10'h006;
  localparam logic [ADDR_W-1:0] OFS_PLL_EFF = 10'h007;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 10'h008;
  localparam logic [ADDR_W-1:0] OFS_FLOAT_STAT = 10'h009;

  // Field positions
  localparam int TXC_FLOAT_LSB = 0;
  localparam int TXC_EDGE_LSB = 4;
  localparam int PLL_M_LSB = 0;
  localparam int PLL_M_W = 5;
  localparam int PLL_N_LSB = 8;
  localparam int PLL_N_W = 6;
  localparam int STS_HOST_LSB = 0;
  localparam int STS_SADDR_LSB = 2;
  localparam int STS_DONE_BIT = 8;
  localparam int STRAP_M_LSB = 11;
  localparam int STRAP_N_LSB = 5;

  // Reset values
  localparam logic [CODE_W-1:0] CODE_RST = 4'h9;
  localparam logic [DATA_W-1:0] TX_CTL_RST = 16'h0000;
  localparam logic [PLL_M_W-1:0] PLL_M_RST = 5'h00;
  localparam logic [PLL_N_W-1:0] PLL_N_RST = 6'h00;

  // Strap capture: edges after release before the synchronised levels are taken
  localparam logic [1:0] STRAP_DLY = 2'h2;

  // Host interface strap codes
  localparam logic [1:0] HOST_INTEL = 2'h0;
  localparam logic [1:0] HOST_MOTOROLA = 2'h1;
  localparam logic [1:0] HOST_MSG_SERIAL = 2'h3;
  localparam int HOST_SERIAL_BIT = 1;

  // Transmit port function codes
  localparam logic [CODE_W-1:0] FN_SYNC = 4'h0;
  localparam logic [CODE_W-1:0] FN_MFS = 4'h1;
  localparam logic [CODE_W-1:0] FN_SIG = 4'h2;
  localparam logic [CODE_W-1:0] FN_TX_CLOCK_IN = 4'h3;
  localparam logic [CODE_W-1:0] FN_MFB = 4'h4;
  localparam logic [CODE_W-1:0] FN_SIGM = 4'h5;
  localparam logic [CODE_W-1:0] FN_DLX = 4'h6;
  localparam logic [CODE_W-1:0] FN_XCLK = 4'h7;
  localparam logic [CODE_W-1:0] FN_FLOAT_HI = 4'h8;
  localparam logic [CODE_W-1:0] FN_GPI = 4'h9;
  localparam logic [CODE_W-1:0] FN_GPOH = 4'hA;
  localparam logic [CODE_W-1:0] FN_GPOL = 4'hB;
  localparam logic [CODE_W-1:0] FN_FLOAT_LO = 4'hE;

  // Direction follows the function; unknown codes stay inputs
  function automatic logic is_output(input logic [CODE_W-1:0] code);
    is_output = (code == FN_MFB) || (code == FN_SIGM) || (code == FN_DLX) || (code == FN_XCLK) ||
                (code == FN_GPOH) || (code == FN_GPOL);
  endfunction : is_output
endpackage : txmux_pkg

//--- rtl/port_cfg_if.sv
interface port_cfg_if;
  logic [txmux_pkg::ADDR_W-1:0] addr;
  logic [txmux_pkg::DATA_W-1:0] wdata;
  logic we;
  logic re;
  logic [txmux_pkg::DATA_W-1:0] aux_rdata;
  logic [txmux_pkg::DATA_W-1:0] rdata;
  logic [txmux_pkg::CFG_W-1:0] cfg;

  modport bank (input addr, input wdata, input we, input re, input aux_rdata, output rdata, output cfg);
  modport ctl (output addr, output wdata, output we, output re, output aux_rdata, input rdata, input cfg);
endinterface : port_cfg_if

//--- rtl/port_cfg_bank.sv
module port_cfg_bank
(
  input wire logic ref_clk, // Core clock
  input wire logic rst_n,   // Async reset, active low
  port_cfg_if.bank bus      // Bus side and config words
);
  logic [txmux_pkg::DATA_W-1:0] mem_r [txmux_pkg::NUM_CH];
  logic [txmux_pkg::DATA_W-1:0] rdata_r;
  logic hit;

  // Port config words occupy the lowest addresses
  assign hit = bus.addr < txmux_pkg::ADDR_W'(txmux_pkg::NUM_CH);

  ////////////////////////////////////////////////////////////////
  // R3: inputs after reset
  // Every port starts as a plain input, one word per channel
  for (genvar c = 0; c < txmux_pkg::NUM_CH; c++)
  begin : g_word
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        mem_r[c] <= {txmux_pkg::NUM_PORT{txmux_pkg::CODE_RST}};
      else if (bus.we && bus.addr == txmux_pkg::ADDR_W'(c))
        mem_r[c] <= bus.wdata;
    end
    assign bus.cfg[c*txmux_pkg::DATA_W +: txmux_pkg::DATA_W] = mem_r[c];
  end

  ////////////////////////////////////////////////////////////////
  // Read data registered here so the top output is a flop
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= '0;
    else if (bus.re)
      rdata_r <= hit ? mem_r[bus.addr[1:0]] : bus.aux_rdata;
  end

  assign bus.rdata = rdata_r;
endmodule : port_cfg_bank

//--- tb/framer_model.sv
module framer_model
(
  input wire logic [txmux_pkg::NUM_PIN-1:0] pin_o,    // Device drive value
  input wire logic [txmux_pkg::NUM_PIN-1:0] pin_oe_n, // Low while device drives
  input wire logic [txmux_pkg::NUM_PIN-1:0] drv_en,   // Framer drives pin
  input wire logic [txmux_pkg::NUM_PIN-1:0] drv_val,  // Framer drive value
  output logic [txmux_pkg::NUM_PIN-1:0] pin_lvl       // Resolved wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up only when nobody drives
  // Undriven pins float high, so a missing pull-up model cannot hide a stuck input
  assign pin_lvl = (~pin_oe_n & pin_o) | (pin_oe_n & drv_en & drv_val) | (pin_oe_n & ~drv_en);
endmodule : framer_model

//--- tb/tb_transmit_port_mux_and_strapping.sv
module tb_transmit_port_mux_and_strapping;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst_n = 0, wr_stb = 0, rd_stb = 0, ready_en = 1, hs_drive_req = 1;
  logic [9:0] addr = '0;
  logic [15:0] wdata = '0, rdata, p_o, p_oe_n, p_lvl, drv_en = '0, drv_val = '0, v;
  logic [3:0] sclk = '0, mfb = '0, f_ctl, so, sm, ss, sc;
  logic [1:0] strap_if = 2'h3, if_sel;
  logic [5:0] s_addr, pll_n;
  logic [4:0] pll_m;
  logic s_valid, hs_o, hs_oe_n;
  int errors = 0, cmp_count = 0;
  ////////////////////////////////////////////////////////////////
  tx_port_mux tx_port_mux_i (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .tx_port_i(p_lvl), .tx_port_o(p_o), .tx_port_oe_n(p_oe_n),
    .tx_system_clock(sclk), .tx_mfb_src(mfb), .tx_sigm_src(4'h0), .tx_dlx_src(4'h0), .tx_xclk_src(4'h0),
    .tx_sync_pulse_in(so), .tx_multiframe_sync_in(sm), .tx_signaling_in(ss), .tx_clock_in(sc),
    .tx_line_float_ctl(f_ctl), .host_if_strap(strap_if), .addr_strap(6'h2A), .data_strap({5'h15, 6'h2B}),
    .host_if_sel(if_sel), .slave_addr(s_addr), .pll_m_divider(pll_m), .pll_n_divider(pll_n),
    .strap_valid(s_valid), .ready_en(ready_en), .hs_drive_req(hs_drive_req), .host_handshake_out(hs_o),
    .host_handshake_oe_n(hs_oe_n));
  framer_model framer_model_i (.pin_o(p_o), .pin_oe_n(p_oe_n), .drv_en(drv_en), .drv_val(drv_val),
    .pin_lvl(p_lvl));
  ////////////////////////////////////////////////////////////////
  // Free-running core clock
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    // Idle edge so a following write never re-raises the strobe in the same step
    @(posedge ref_clk);
  endtask : wr
  // Data sampled one edge late; it holds until the next read
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(posedge ref_clk);
    d = rdata;
  endtask : rd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(p_oe_n, 16'hFFFF);
    rd(txmux_pkg::OFS_PORT_CFG0, v);
    chk(v, 16'h9999);
    strap_if <= 2'h0;
    rd(txmux_pkg::OFS_STRAP_STAT, v);
    chk(v, 16'h01AB);
    chk({15'h0000, s_valid}, 16'h0001);
    chk({11'h000, pll_m}, 16'h0015);
    chk({10'h000, pll_n}, 16'h002B);
  endtask : t_reset
  task automatic t_dir;
    wr(txmux_pkg::OFS_PORT_CFG0, 16'h94BA);
    cyc(2);
    chk({12'h000, p_oe_n[3:0]}, 16'h0008);
    chk({14'h0000, p_o[1:0]}, 16'h0001);
  endtask : t_dir
  task automatic t_float;
    drv_en <= 16'h0110;
    drv_val <= 16'h0100;
    wr(txmux_pkg::OFS_PORT_CFG0 + 10'h001, 16'h999E);
    wr(txmux_pkg::OFS_PORT_CFG0 + 10'h002, 16'h9998);
    cyc(6);
    chk({12'h000, f_ctl}, 16'h0006);
    wr(txmux_pkg::OFS_TX_CTL, 16'h0008);
    drv_en <= 16'h0100;
    cyc(6);
    chk({12'h000, f_ctl}, 16'h000C);
    rd(txmux_pkg::OFS_PIN_LEVEL, v);
    chk(v & 16'hF000, 16'hF000);
  endtask : t_float
  task automatic t_map;
    wr(txmux_pkg::OFS_PORT_CFG0 + 10'h003, 16'h9993);
    cyc(4);
    chk({so, sm, ss, sc}, 16'h0008);
    rd(10'h3FF, v);
    chk(v, 16'h0000);
    chk({15'h0000, hs_oe_n}, 16'h0001);
    chk({14'h0000, if_sel}, 16'h0003);
  endtask : t_map
  // Marker on ch0 port 2 launches only on the selected system clock edge
  task automatic t_edge;
    mfb <= 4'h0;
    cyc(4);
    chk({15'h0000, p_o[2]}, 16'h0001);
    sclk <= 4'h1;
    cyc(5);
    chk({15'h0000, p_o[2]}, 16'h0000);
    wr(txmux_pkg::OFS_TX_CTL, 16'h0018);
    mfb <= 4'hF;
    sclk <= 4'h0;
    cyc(5);
    chk({15'h0000, p_o[2]}, 16'h0001);
    mfb <= 4'h0;
    sclk <= 4'h1;
    cyc(5);
    chk({15'h0000, p_o[2]}, 16'h0001);
  endtask : t_edge
  // Mid-run reset with the interface strap now on the parallel bus
  task automatic t_par;
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(5);
    chk({14'h0000, if_sel}, 16'h0000);
    chk({10'h000, s_addr}, 16'h0000);
    chk({14'h0000, hs_o, hs_oe_n}, 16'h0000);
    wr(txmux_pkg::OFS_PLL_CFG, 16'h0A07);
    cyc(2);
    chk({11'h000, pll_m}, 16'h0007);
    chk({10'h000, pll_n}, 16'h000A);
    ready_en <= 1'b0;
    cyc(4);
    chk({15'h0000, hs_oe_n}, 16'h0001);
  endtask : t_par
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(6);
    t_reset();
    t_dir();
    t_float();
    t_edge();
    t_map();
    t_par();
    end_sim();
  end
  // Watchdog well beyond the roughly 83 cycles of the sequence
  initial
  begin
    #20000;
    errors++;
    end_sim();
  end
endmodule : tb_transmit_port_mux_and_strapping
